// ### hdl/agps_seq.sv
// agps_seq: high-side pwm turn-on/turn-off gate phase sequencer
`timescale 1ns/1ps

// Notes on behaviour
// - active fw rise: cross-current, low-side discharges first
// - then high-side pre-charge with adaptive code
// - charge code, measure turn-on until high threshold
// - post-charge ramps one step per tick to ceiling
// - adapt only in the two adaptive modes
// - adaptive code clamped minimum step to ceiling
// - pwm enable loads min(initial, ceiling) pre-charge
// - unfiltered: long delay raises, short lowers
// - step one or two per select bit
// - filtered: change only if two agree
// - fall edge: active fw delays turn-off by crossover time, passive by none
// - then pre-discharge with adaptive code
// - discharge code, measure turn-off, end at crossover
// - low-side off, then freewheel charge if low
// - pwm enable loads min(initial, ceiling) pre-discharge
// - unfiltered pre-discharge adaptation by turn-off delay
// - filtered pre-discharge adaptation needs two agreeing
// - passive: complementary switch always off
// - passive: no cross-current at rising edge
// - passive: no cross-current at falling edge
module agps_seq (
	input  wire logic       mclk_in,        // 100 mhz clock
	input  wire logic       srst_in,        // sync reset, high
	input  wire logic       pwm_input_line_in,   // synced pwm
	input  wire logic       bd_tick_in,     // bridge driver clock enable
	input  wire logic       active_freewheel_enable_in, // afw
	input  wire logic [1:0] adaptive_gate_mode_in,     // mode field
	input  wire logic       adaptation_filter_enable_in, // filter
	input  wire logic       adaptation_step_select_in,  // step size
	input  wire logic       postcharge_disable_in,      // skip ramp
	input  wire logic       bridge_pwm_enable_set_in,   // spi set pulse
	input  wire logic [5:0] precharge_initial_code_in,  // init code
	input  wire logic [5:0] predischarge_initial_code_in, // init code
	input  wire logic [5:0] current_ceiling_code_in,    // ceiling
	input  wire logic [5:0] charge_current_code_in,     // charge code
	input  wire logic [5:0] discharge_current_code_in,  // discharge
	input  wire logic [5:0] freewheel_current_code_in,  // fw code
	input  wire logic [7:0] freewheel_crossover_time_in, // cycles
	input  wire logic [7:0] active_crossover_time_in,   // cycles
	input  wire logic [7:0] precharge_duration_in,      // cycles
	input  wire logic [7:0] predischarge_duration_in,   // cycles
	input  wire logic [7:0] overvoltage_filter_time_in, // cycles
	input  wire logic [9:0] turn_on_delay_target_in,    // cycles
	input  wire logic [9:0] turn_off_delay_target_in,   // cycles
	input  wire logic       switch_node_high_in,  // above high thr
	input  wire logic       switch_node_low_in,   // below low thr
	output logic            hs_source_out,  // high-side sourcing
	output logic            hs_sink_out,    // high-side sinking
	output logic [5:0]      hs_code_out,    // high-side code
	output logic            ls_source_out,  // low-side sourcing
	output logic            ls_sink_out,    // low-side sinking
	output logic [5:0]      ls_code_out,    // low-side code
	output logic [9:0]      eff_turn_on_out,  // measured on delay
	output logic [9:0]      eff_turn_off_out, // measured off delay
	output logic [5:0]      precharge_current_code_out,   // adaptive
	output logic [5:0]      predischarge_current_code_out // adaptive
);
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [9:0] {
		ST_OFF   = 10'h001,   // high-side off, idle
		ST_CCPON = 10'h002,   // cross-current before turn-on
		ST_PCHG  = 10'h004,   // pre-charge
		ST_CHG   = 10'h008,   // charge, measuring
		ST_POST  = 10'h010,   // post-charge ramp
		ST_ON    = 10'h020,   // high-side held on
		ST_SYM   = 10'h040,   // symmetrization delay
		ST_PDCHG = 10'h080,   // pre-discharge
		ST_DCHG  = 10'h100,   // discharge, measuring
		ST_FWON  = 10'h200    // low-side freewheel charge
	} agps_st_t;

	typedef struct packed {
		agps_st_t   st;       // phase
		logic       pwm;      // last pwm level
		logic [5:0] ramp;     // post-charge code
		logic [9:0] meas;     // running delay count
		logic [9:0] ton;      // last turn-on delay
		logic [9:0] toff;     // last turn-off delay
		logic       son;      // turn-on sample pulse
		logic       soff;     // turn-off sample pulse
		logic       ccp;      // active crossover running
	} agps_seq_t;

	agps_seq_t s_q;           // registered state
	agps_seq_t s_d;           // next state

	// ****************************************************************
	// timers and adaptive codes
	// ****************************************************************
	logic       t_load;       // load phase timer
	logic [7:0] t_val;        // phase timer value
	logic       t_done;       // phase timer expired
	logic       c_load;       // load crossover/filter timer
	logic [7:0] c_val;        // crossover/filter timer value
	logic       c_done;       // crossover/filter timer expired
	logic       adapt_en;     // adaptive mode selected
	logic [5:0] pchg_code;    // adaptive pre-charge code
	logic [5:0] pdchg_code;   // adaptive pre-discharge code
	logic       rise;         // pwm rising edge
	logic       fall;         // pwm falling edge
	logic       afw;          // active freewheel

	assign adapt_en = adaptive_gate_mode_in[1];
	assign rise     = pwm_input_line_in && !s_q.pwm;
	assign fall     = !pwm_input_line_in && s_q.pwm;
	assign afw      = active_freewheel_enable_in;

	// phase timer for pre phases, symmetrization, crossover
	agps_timer u_tph (
		.mclk_in  (mclk_in),
		.srst_in  (srst_in),
		.load_in  (t_load),
		.value_in (t_val),
		.done_out (t_done)
	);

	// second timer: active crossover and filter windows
	agps_timer u_tcc (
		.mclk_in  (mclk_in),
		.srst_in  (srst_in),
		.load_in  (c_load),
		.value_in (c_val),
		.done_out (c_done)
	);

	// each instance holds its own codes and history
	agps_adapt u_pchg (
		.mclk_in      (mclk_in),
		.srst_in      (srst_in),
		.init_in      (bridge_pwm_enable_set_in),
		.init_code_in (precharge_initial_code_in),
		.ceil_in      (current_ceiling_code_in),
		.sample_in    (s_q.son),
		.meas_in      (s_q.ton),
		.target_in    (turn_on_delay_target_in),
		.adapt_en_in  (adapt_en),
		.filt_in      (adaptation_filter_enable_in),
		.step2_in     (adaptation_step_select_in),
		.code_out     (pchg_code)
	);

	agps_adapt u_pdchg (
		.mclk_in      (mclk_in),
		.srst_in      (srst_in),
		.init_in      (bridge_pwm_enable_set_in),
		.init_code_in (predischarge_initial_code_in),
		.ceil_in      (current_ceiling_code_in),
		.sample_in    (s_q.soff),
		.meas_in      (s_q.toff),
		.target_in    (turn_off_delay_target_in),
		.adapt_en_in  (adapt_en),
		.filt_in      (adaptation_filter_enable_in),
		.step2_in     (adaptation_step_select_in),
		.code_out     (pdchg_code)
	);

	// ****************************************************************
	// sequencer next state
	// ****************************************************************
	always_comb begin
		s_d      = s_q;
		s_d.pwm  = pwm_input_line_in;
		s_d.son  = 1'b0;
		s_d.soff = 1'b0;
		t_load   = 1'b0;
		t_val    = 8'h00;
		c_load   = 1'b0;
		c_val    = 8'h00;
		// delay counter saturates instead of wrapping
		if (s_q.meas != agps_pkg::DLY_SAT) begin
			s_d.meas = s_q.meas + 10'h001;
		end
		unique case (s_q.st)
			ST_OFF, ST_FWON: begin
				// filter window ends the freewheel charge
				if (s_q.st == ST_FWON && c_done) begin
					s_d.st = ST_OFF;
				end
				if (rise) begin
					t_load = 1'b1;
					if (afw) begin
						// low-side discharged first, high-side off
						t_val  = freewheel_crossover_time_in;
						s_d.st = ST_CCPON;
					end else begin
						// passive: straight to pre-charge
						t_val  = precharge_duration_in;
						s_d.st = ST_PCHG;
					end
					s_d.meas = 10'h000;
				end
			end
			ST_CCPON: begin
				if (fall) begin
					s_d.st = ST_OFF;
				end else if (t_done) begin
					t_load   = 1'b1;
					t_val    = precharge_duration_in;
					s_d.st   = ST_PCHG;
					s_d.meas = 10'h000;
				end
			end
			ST_PCHG: begin
				if (t_done || adaptive_gate_mode_in == agps_pkg::AGC_NONE) begin
					s_d.st = ST_CHG;
				end
			end
			ST_CHG: begin
				if (switch_node_high_in) begin
					// turn-on delay captured at high threshold
					s_d.ton  = s_q.meas;
					s_d.son  = 1'b1;
					s_d.ramp = charge_current_code_in;
					c_load   = 1'b1;
					c_val    = overvoltage_filter_time_in;
					s_d.st   = postcharge_disable_in ? ST_ON : ST_POST;
				end
			end
			ST_POST: begin
				// step once per driver tick up to the ceiling
				if (bd_tick_in && s_q.ramp < current_ceiling_code_in) begin
					s_d.ramp = s_q.ramp + 6'h01;
				end
				if (c_done) begin
					s_d.st = ST_ON;
				end
			end
			ST_ON: begin
				s_d.st = ST_ON;
			end
			ST_SYM: begin
				if (t_done) begin
					// turn-off starts, crossover runs alongside
					t_load   = 1'b1;
					t_val    = predischarge_duration_in;
					c_load   = 1'b1;
					c_val    = active_crossover_time_in;
					s_d.ccp  = afw;
					s_d.meas = 10'h000;
					s_d.st   = ST_PDCHG;
				end
			end
			ST_PDCHG: begin
				if (t_done || adaptive_gate_mode_in == agps_pkg::AGC_NONE) begin
					s_d.st = ST_DCHG;
				end
			end
			ST_DCHG: begin
				if (c_done) begin
					// discharge ends with the active crossover
					s_d.toff = s_q.meas;
					s_d.soff = 1'b1;
					s_d.ccp  = 1'b0;
					c_load   = afw;
					c_val    = overvoltage_filter_time_in;
					s_d.st   = afw ? ST_FWON : ST_OFF;
				end
			end
			default: begin
				s_d.st = ST_OFF;
			end
		endcase
		// falling edge from any on-side phase starts symmetrization
		if (fall && (s_q.st == ST_PCHG || s_q.st == ST_CHG ||
		             s_q.st == ST_POST || s_q.st == ST_ON)) begin
			t_load = 1'b1;
			t_val  = afw ? freewheel_crossover_time_in : 8'h00;
			s_d.st = ST_SYM;
		end
	end

	// ****************************************************************
	// register
	// ****************************************************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_q <= '{st: ST_OFF, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// gate outputs
	// ****************************************************************
	always_comb begin
		logic [5:0] pre_on;
		logic [5:0] pre_off;
		// fixed-initial mode bypasses adaptation
		pre_on  = (adaptive_gate_mode_in == agps_pkg::AGC_INIT) ?
		          precharge_initial_code_in : pchg_code;
		pre_off = (adaptive_gate_mode_in == agps_pkg::AGC_INIT) ?
		          predischarge_initial_code_in : pdchg_code;
		hs_source_out = 1'b0;
		hs_sink_out   = 1'b0;
		hs_code_out   = agps_pkg::CODE_ZERO;
		ls_source_out = 1'b0;
		ls_sink_out   = 1'b0;
		ls_code_out   = agps_pkg::CODE_ZERO;
		unique case (s_q.st)
			ST_CCPON: begin
				ls_sink_out = 1'b1;
				ls_code_out = freewheel_current_code_in;
			end
			ST_PCHG: begin
				hs_source_out = 1'b1;
				hs_code_out   = pre_on;
			end
			ST_CHG: begin
				hs_source_out = 1'b1;
				hs_code_out   = charge_current_code_in;
			end
			ST_POST, ST_ON: begin
				hs_source_out = 1'b1;
				hs_code_out   = s_q.ramp;
			end
			ST_SYM: begin
				hs_source_out = 1'b1;
				hs_code_out   = s_q.ramp;
			end
			ST_PDCHG: begin
				hs_sink_out = 1'b1;
				hs_code_out = pre_off;
			end
			ST_DCHG: begin
				hs_sink_out = 1'b1;
				hs_code_out = discharge_current_code_in;
			end
			ST_FWON: begin
				// charge only while the node sits low; passive never here
				ls_source_out = afw && switch_node_low_in;
				ls_code_out   = freewheel_current_code_in;
			end
			default: begin
				hs_sink_out = 1'b0;
			end
		endcase
	end

	assign eff_turn_on_out               = s_q.ton;
	assign eff_turn_off_out              = s_q.toff;
	assign precharge_current_code_out    = pchg_code;
	assign predischarge_current_code_out = pdchg_code;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_rise_afw;
		s_q.st == ST_OFF && rise && afw;
	endsequence

	property p_ccp_first;
		@(posedge mclk_in) disable iff (srst_in)
		s_rise_afw |=> s_q.st == ST_CCPON;
	endproperty
	a_ccp_first: assert property (p_ccp_first) else $error("no ccp");

	property p_passive_skip;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_OFF && rise && !afw |=> s_q.st == ST_PCHG;
	endproperty
	a_passive_skip: assert property (p_passive_skip) else $error("ccp kept");

	property p_ls_off;
		@(posedge mclk_in) disable iff (srst_in)
		!afw |-> !ls_source_out;
	endproperty
	a_ls_off: assert property (p_ls_off) else $error("ls on passive");

	property p_ccp_hs_off;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_CCPON |-> !hs_source_out && ls_sink_out;
	endproperty
	a_ccp_hs_off: assert property (p_ccp_hs_off) else $error("hs during ccp");

	property p_chg_end;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_CHG && switch_node_high_in && !fall
		|=> s_q.st != ST_CHG && s_q.son;
	endproperty
	a_chg_end: assert property (p_chg_end) else $error("charge not ended");

	property p_ramp;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_POST && bd_tick_in && !c_done && !fall &&
		s_q.ramp < current_ceiling_code_in |=> s_q.ramp == $past(s_q.ramp) + 6'h01;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp step");

	property p_sym;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_ON && fall && afw
		|=> s_q.st == ST_SYM ##1 hs_source_out;
	endproperty
	a_sym: assert property (p_sym) else $error("no symmetrization");

	property p_pdchg;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_PDCHG |-> hs_sink_out && !ls_source_out;
	endproperty
	a_pdchg: assert property (p_pdchg) else $error("pre-discharge drive");

	property p_pchg_drive;
		@(posedge mclk_in) disable iff (srst_in)
		s_q.st == ST_PCHG && adapt_en |-> hs_code_out == pchg_code;
	endproperty
	a_pchg_drive: assert property (p_pchg_drive) else $error("pre-charge code");
endmodule : agps_seq

// ### hdl/agps_pkg.sv
// agps_pkg: shared constants for the adaptive gate pwm sequencer
package agps_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int CODE_W  = 6;                  // gate current code width
	localparam int TIME_W  = 8;                  // phase timer width
	localparam int DLY_W   = 10;                 // delay measurement width

	// ****************************************************************
	// codes and reset values
	// ****************************************************************
	localparam logic [5:0] CODE_MIN  = 6'h00;    // minimum current step
	localparam logic [5:0] CODE_ZERO = 6'h00;    // no drive
	localparam logic [1:0] AGC_ADPT  = 2'h2;     // mode msb set -> adaptive
	localparam logic [1:0] AGC_INIT  = 2'h1;     // fixed initial codes
	localparam logic [1:0] AGC_NONE  = 2'h0;     // pre phases cut to one cycle
	localparam logic [9:0] DLY_SAT   = 10'h3FF;  // measurement saturation

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_NS      = 10;             // mclk period
	localparam int MIN_PHASE_NS = 10;            // shortest phase
	localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + CLK_NS - 1) / CLK_NS;

endpackage : agps_pkg

// ### hdl/agps_timer.sv
// agps_timer: loadable down counter for phase durations
`timescale 1ns/1ps
module agps_timer (
	input  wire logic       mclk_in,       // system clock
	input  wire logic       srst_in,       // sync reset
	input  wire logic       load_in,       // load strobe
	input  wire logic [7:0] value_in,      // cycles to count
	output logic            done_out       // high when zero
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] cnt;                    // remaining cycles
	} agps_tmr_t;
	agps_tmr_t s_q;                         // registered state
	agps_tmr_t s_d;                         // next state

	// next state: load wins over counting
	always_comb begin
		s_d = s_q;
		if (load_in) begin
			s_d.cnt = value_in;
		end else if (s_q.cnt != 8'h00) begin
			s_d.cnt = s_q.cnt - 8'h01;
		end
	end

	// register
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// expiry comes from the register alone; gating it with the load
	// strobe would close a loop through the sequencer's next-state logic
	assign done_out = (s_q.cnt == 8'h00);
endmodule : agps_timer

// ### hdl/agps_adapt.sv
// agps_adapt: one self-adapting pre-phase current code
`timescale 1ns/1ps
module agps_adapt (
	input  wire logic       mclk_in,       // system clock
	input  wire logic       srst_in,       // sync reset
	input  wire logic       init_in,       // pwm enable set pulse
	input  wire logic [5:0] init_code_in,  // initial code
	input  wire logic [5:0] ceil_in,       // ceiling code
	input  wire logic       sample_in,     // measurement done pulse
	input  wire logic [9:0] meas_in,       // measured delay
	input  wire logic [9:0] target_in,     // target delay
	input  wire logic       adapt_en_in,   // adaptive mode
	input  wire logic       filt_in,       // filter enable
	input  wire logic       step2_in,      // two-step select
	output logic [5:0]      code_out       // current code
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [5:0] code;                   // adaptive code
		logic       prev_v;                 // previous sample valid
		logic       prev_hi;                // previous was too long
		logic       prev_lo;                // previous was too short
	} agps_adp_t;
	agps_adp_t s_q;                         // registered state
	agps_adp_t s_d;                         // next state

	// next state: compare, filter, step, clamp
	always_comb begin
		logic       hi;
		logic       lo;
		logic       up;
		logic       dn;
		logic [6:0] stp;
		logic [6:0] sum;
		hi  = 1'b0;
		lo  = 1'b0;
		up  = 1'b0;
		dn  = 1'b0;
		stp = step2_in ? 7'h02 : 7'h01;
		sum = {1'b0, s_q.code};
		s_d = s_q;
		if (init_in) begin
			// smaller of initial and ceiling
			s_d.code   = (init_code_in < ceil_in) ? init_code_in : ceil_in;
			s_d.prev_v = 1'b0;
		end else if (sample_in && adapt_en_in) begin
			hi = meas_in > target_in;
			lo = meas_in < target_in;
			if (filt_in) begin
				// both of last two on same side, else hold
				up = hi && s_q.prev_v && s_q.prev_hi;
				dn = lo && s_q.prev_v && s_q.prev_lo;
			end else begin
				up = hi;
				dn = lo;
			end
			if (up) begin
				sum = {1'b0, s_q.code} + stp;
			end else if (dn) begin
				sum = ({1'b0, s_q.code} > stp) ? {1'b0, s_q.code} - stp
				      : {1'b0, agps_pkg::CODE_MIN};
			end
			// clamp between minimum step and ceiling
			if (sum > {1'b0, ceil_in}) begin
				sum = {1'b0, ceil_in};
			end
			s_d.code    = sum[5:0];
			s_d.prev_v  = 1'b1;
			s_d.prev_hi = hi;
			s_d.prev_lo = lo;
		end
	end

	// register
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign code_out = s_q.code;

	// code never above ceiling after an adaptation step
	property p_ceil;
		@(posedge mclk_in) disable iff (srst_in)
		$past(sample_in) && $past(adapt_en_in) && !$past(init_in)
		|-> code_out <= $past(ceil_in);
	endproperty
	a_ceil: assert property (p_ceil) else $error("code above ceiling");
endmodule : agps_adapt

// ### sim/agps_bridge_model.sv
// agps_bridge_model: behavioural half-bridge switch node for the sequencer
`timescale 1ns/1ps
module agps_bridge_model #(
	parameter int ON_DLY  = 12, // source cycles to pass high threshold
	parameter int OFF_DLY = 6   // sink cycles to pass low threshold
) (
	input  wire logic mclk_in,      // system clock
	input  wire logic hs_source_in, // high-side gate sourcing
	input  wire logic hs_sink_in,   // high-side gate sinking
	output logic      sw_high_out,  // node above high threshold
	output logic      sw_low_out    // node below low threshold
);
	int   cnt_q = 0;     // cycles of gate current toward a change
	logic node_q = 1'b0; // switch node level, low at start
	// a node moves only after enough gate charge; an idle gate holds it
	always @(posedge mclk_in) begin
		if (hs_source_in && !node_q) begin
			cnt_q <= (cnt_q + 1 >= ON_DLY) ? 0 : cnt_q + 1;
			node_q <= (cnt_q + 1 >= ON_DLY);
		end else if (hs_sink_in && node_q) begin
			cnt_q <= (cnt_q + 1 >= OFF_DLY) ? 0 : cnt_q + 1;
			node_q <= !(cnt_q + 1 >= OFF_DLY);
		end else begin
			cnt_q <= 0;
		end
	end
	assign sw_high_out = node_q;
	assign sw_low_out  = !node_q;
endmodule : agps_bridge_model

// ### sim/tb_agps_seq.sv
// tb_agps_seq: directed bench for the adaptive gate pwm sequencer
`timescale 1ns/1ps
module tb_agps_seq;
	// ************************************************************
	// stimulus and observed signals
	// ************************************************************
	logic       mclk_in = 1'b0; // 100 mhz clock
	logic       srst_in = 1'b1; // sync reset
	logic       pwm = 1'b0;     // synced pwm level
	logic       tick = 1'b0;    // driver clock enable, every 2nd cycle
	logic       afw = 1'b1;     // active freewheel
	logic [1:0] mode = 2'h2;    // gate mode
	logic       filt = 1'b0;    // filter enable
	logic       st2 = 1'b0;     // two-step select
	logic       init = 1'b0;    // enable set pulse
	logic [5:0] pre_i = 6'h05;  // initial pre-charge code
	logic [5:0] pdc_i = 6'h07;  // initial pre-discharge code
	logic [9:0] tgt = 10'h002;  // delay target, both edges
	logic [5:0] ceil = 6'h14, chg = 6'h0A, dis = 6'h1E, fwc = 6'h0C;
	logic [7:0] t_pre = 8'h04;  // shorter than blanking
	logic [7:0] t_pdc = 8'h03;  // shorter than active crossover
	logic       sw_hi, sw_lo, hs_src, hs_snk, ls_src, ls_snk;
	logic [5:0] hs_code, ls_code, pre_q, pdc_q;
	int         err_total = 0;
	int         n_compared = 0;

	always #5 mclk_in = ~mclk_in;
	always @(negedge mclk_in) tick <= ~tick;

	agps_seq dut (
		.mclk_in(mclk_in), .srst_in(srst_in),
		.pwm_input_line_in(pwm), .bd_tick_in(tick),
		.active_freewheel_enable_in(afw), .adaptive_gate_mode_in(mode),
		.adaptation_filter_enable_in(filt),
		.adaptation_step_select_in(st2),
		.postcharge_disable_in(1'b0), .bridge_pwm_enable_set_in(init),
		.precharge_initial_code_in(pre_i),
		.predischarge_initial_code_in(pdc_i),
		.current_ceiling_code_in(ceil), .charge_current_code_in(chg),
		.discharge_current_code_in(dis), .freewheel_current_code_in(fwc),
		.freewheel_crossover_time_in(8'h04),
		.active_crossover_time_in(8'h08),
		.precharge_duration_in(t_pre), .predischarge_duration_in(t_pdc),
		.overvoltage_filter_time_in(8'h28),
		.turn_on_delay_target_in(tgt), .turn_off_delay_target_in(tgt),
		.switch_node_high_in(sw_hi), .switch_node_low_in(sw_lo),
		.hs_source_out(hs_src), .hs_sink_out(hs_snk), .hs_code_out(hs_code),
		.ls_source_out(ls_src), .ls_sink_out(ls_snk), .ls_code_out(ls_code),
		.eff_turn_on_out(), .eff_turn_off_out(),
		.precharge_current_code_out(pre_q),
		.predischarge_current_code_out(pdc_q)
	);

	agps_bridge_model bridge (.mclk_in(mclk_in), .hs_source_in(hs_src),
		.hs_sink_in(hs_snk), .sw_high_out(sw_hi), .sw_low_out(sw_lo));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// enable set pulse with fresh initial codes
	task automatic load(input logic [5:0] p, input logic [5:0] d);
		pre_i = p;
		pdc_i = d;
		@(negedge mclk_in) init = 1'b1;
		@(negedge mclk_in) init = 1'b0;
		repeat (3) @(negedge mclk_in);
	endtask : load

	// one pwm period; dp/dd codes expected in use, ep/ed after it
	task automatic run(input logic [1:0] m, input logic f, input logic s,
		input logic [9:0] t, input logic a, input logic [5:0] dp,
		input logic [5:0] dd, input logic [5:0] ep, input logic [5:0] ed);
		logic [7:0] sn; // seen: lsfirst pre chg ceil pdc dc fw anyls
		sn = 8'h00;
		{mode, filt, st2, tgt, afw} = {m, f, s, t, a};
		pwm = 1'b1;
		for (int i = 0; i < 180; i++) begin
			@(negedge mclk_in);
			if (i == 89) pwm = 1'b0;
			if (i == 3) chk(10'(hs_src), 10'(!a));
			if (i == 92 && a) chk(10'({hs_src, hs_snk}), 10'h002);
			if (ls_snk && !sn[6]) sn[7] = 1'b1;
			if (hs_src && hs_code == dp) sn[6] = 1'b1;
			if (hs_src && hs_code == chg) sn[5] = 1'b1;
			if (hs_src && hs_code == ceil) sn[4] = 1'b1;
			if (hs_snk && hs_code == dd) sn[3] = 1'b1;
			if (hs_snk && hs_code == dis) sn[2] = 1'b1;
			if (ls_src && ls_code == fwc) sn[1] = 1'b1;
			if (ls_src || ls_snk) sn[0] = 1'b1;
		end
		chk(10'(sn[7:6]), 10'({a, 1'b1}));
		chk(10'(sn[5:2]), 10'h00F);
		chk(10'(sn[1:0]), 10'({a, a}));
		chk({pre_q, 4'h0}, {ep, 4'h0});
		chk({pdc_q, 4'h0}, {ed, 4'h0});
	endtask : run

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		repeat (20) @(negedge mclk_in);
		srst_in = 1'b0;
		@(negedge mclk_in);
		chk({hs_src, hs_snk, ls_src, ls_snk, hs_code}, 10'h000);
		load(6'h05, 6'h07);
		chk({pre_q, pdc_q[3:0]}, {6'h05, 4'h7});
		run(2'h2, 1'b0, 1'b0, 10'h002, 1'b1, 6'h05, 6'h07, 6'h06, 6'h08);
		run(2'h2, 1'b0, 1'b1, 10'h002, 1'b1, 6'h06, 6'h08, 6'h08, 6'h0A);
		run(2'h2, 1'b0, 1'b0, 10'h3FF, 1'b1, 6'h08, 6'h0A, 6'h07, 6'h09);
		run(2'h2, 1'b0, 1'b0, 10'h3FF, 1'b0, 6'h07, 6'h09, 6'h06, 6'h08);
		load(6'h05, 6'h07);
		run(2'h2, 1'b1, 1'b0, 10'h3FF, 1'b1, 6'h05, 6'h07, 6'h05, 6'h07);
		run(2'h2, 1'b1, 1'b0, 10'h3FF, 1'b1, 6'h05, 6'h07, 6'h04, 6'h06);
		run(2'h1, 1'b0, 1'b0, 10'h002, 1'b1, 6'h05, 6'h07, 6'h04, 6'h06);
		load(6'h13, 6'h28);
		chk({pre_q, pdc_q[3:0]}, {6'h13, 4'h4});
		run(2'h2, 1'b0, 1'b1, 10'h002, 1'b1, 6'h13, 6'h14, 6'h14, 6'h14);
		load(6'h01, 6'h00);
		run(2'h2, 1'b0, 1'b1, 10'h3FF, 1'b1, 6'h01, 6'h00, 6'h00, 6'h00);
		run(2'h0, 1'b0, 1'b0, 10'h002, 1'b1, 6'h00, 6'h00, 6'h00, 6'h00);
		end_sim();
	end

	// a hung sequence ends the run as a failure
	initial begin
		repeat (6000) @(posedge mclk_in);
		err_total++;
		end_sim();
	end
endmodule : tb_agps_seq
